// file: core/eia_top.sv
// Extended indexed addressing block: pointer subtract, subtract and
// return, and operand address forming, driven over an AHB-Lite slave.
// Assumes one clock, a bus master issuing single word transfers, and a
// host that loads pointers, bank, return top and opcode before a launch.
//
// Functional notes
// - Subtract literal 0..63 from chosen pointer.
// - Select field 11 means subtract and return.
// - Subtract from pointer two, then load return top.
// - Subtract and return takes two cycles, second idle.
// - Disabled: access bit picks access or selected bank.
// - Enabled, access 0, operand to 5Fh: pointer two indexed.
// - Indexing applies to all byte and bit ops.
// - One enable for new opcodes and indexing.
// - Pointer two zero matches legacy access addresses.
// - Operands above 5Fh keep their normal meaning.
// - Indexed address is pointer two plus offset.
// - Extended enable resets to zero, disabled.
`timescale 1ns/1ps
`default_nettype none
`include "eia_params.svh"

module eia_top (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire eia_pkg::eia_ahb_req_t i_ahb,
  output eia_pkg::eia_ahb_rsp_t o_ahb,
  output eia_pkg::eia_core_out_t o_core
);
  import eia_pkg::*;

  // Register map seen by software, byte offsets on the bus:
  //   00 control, bit 0 opens the extended set (new opcodes and indexing)
  //   04 pointer zero, 12 bits
  //   08 pointer one, 12 bits
  //   0c pointer two, the frame pointer, 12 bits
  //   10 return stack top, 21 bits
  //   14 program counter, 21 bits
  //   18 bank select, 4 bits
  //   1c opcode; a write while idle launches one instruction
  //   20 status: busy, indexed, operand valid, executed count
  //   24 last formed operand address, read only
  // Words above the register width read back as zero.
  //
  // Bus behaviour:
  //   The slave never stretches a transfer; hreadyout stays high.
  //   Read data is looked up in the address phase and registered, so it
  //   stands for exactly the data phase and is zero in every other cycle.
  //   Write data is applied at the end of the data phase.
  //   A read of a register in the cycle its write lands returns the old
  //   word; masters that need the new one leave one idle cycle between.
  //   The response is always OKAY; unmapped or high addresses are ignored.
  //
  // Execution timing with the divider at one clock per phase:
  //   D     data phase of the opcode write
  //   D+1   first phase, decode
  //   D+2   second phase, operand address formed
  //   D+3   operand address, valid and indexed flags visible
  //   D+4   last phase, pointer and program counter written
  //   D+5   results visible; plain instructions are no longer busy
  // The subtract-and-return form loads the program counter from the
  // return top at D+5, pulses the return flag there, and then spends a
  // whole idle instruction cycle, so busy falls only at D+9.
  //
  // Hazards and limits:
  //   Writes that arrive while busy are dropped, not queued. Software must
  //   poll busy before touching any register, or the write is lost. The
  //   trade is a simpler sequencer against a silent drop.
  //   The pointer subtract wraps modulo the pointer width and raises no
  //   flag; callers that need underflow detection compare beforehand.
  //   The executed instruction count wraps at its width without warning.
  //   Indexing only affects the formed operand address; no data memory
  //   lives in this block, so reads and writes of the operand are the
  //   surrounding core's business.
  //
  // Decode summary:
  //   Subtract opcodes decode only with the extended set open; with it
  //   closed they execute as a plain step of the program counter.
  //   A select field of three turns the subtract into the return form,
  //   which always works on pointer two.
  //   Byte and bit operations carry the access bit; with the extended set
  //   open, access bit clear and operand at or below the limit, the
  //   operand is an offset from pointer two.
  //   Operands above the limit, or with the access bit set, keep their
  //   legacy meaning: high access region or the selected bank.
  //   A zero frame pointer maps indexed operands onto the low access
  //   region, which keeps legacy code working with the set open.

  // Whole state of the block in one record
  typedef struct packed {
    logic ext_en;
    logic [2:0][`EIA_PTR_W-1:0] ptr;
    logic [`EIA_PC_W-1:0] return_stack_top;
    logic [`EIA_PC_W-1:0] pc;
    logic [3:0] bank;
    logic [`EIA_OPC_W-1:0] opc;
    eia_phase_t st;
    logic busy;
    logic [1:0] nop_cnt;
    logic [3:0] div;
    logic [`EIA_PTR_W-1:0] ea;
    logic ea_valid;
    logic indexed;
    logic ret_pulse;
    logic [`EIA_CNT_W-1:0] icount;
    logic wr_pend;
    logic wr_map;
    logic [7:0] wr_ofs;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
  } eia_state_t;

  eia_state_t s_q;
  eia_state_t s_d;

  eia_dec_t dec;
  logic [`EIA_PTR_W-1:0] agen_addr;
  logic agen_idx;
  logic [`EIA_PTR_W-1:0] sub_in;
  logic [`EIA_PTR_W-1:0] sub_out;
  logic [1:0] sel_eff;
  logic tick;
  logic acc;

  // Register read view; reads of unmapped words return zero
  function automatic logic [31:0] rd_word(input eia_state_t st, input logic [7:0] ofs);
    logic [31:0] w;
    w = 32'h0;
    case (ofs)
      `EIA_OFS_CTRL: w[`EIA_CTRL_EXT_BIT] = st.ext_en;
      `EIA_OFS_PTR0: w[`EIA_PTR_W-1:0] = st.ptr[0];
      `EIA_OFS_PTR1: w[`EIA_PTR_W-1:0] = st.ptr[1];
      `EIA_OFS_PTR2: w[`EIA_PTR_W-1:0] = st.ptr[2];
      `EIA_OFS_TOS: w[`EIA_PC_W-1:0] = st.return_stack_top;
      `EIA_OFS_PC: w[`EIA_PC_W-1:0] = st.pc;
      `EIA_OFS_BANK: w[3:0] = st.bank;
      `EIA_OFS_OPC: w[`EIA_OPC_W-1:0] = st.opc;
      `EIA_OFS_STAT: begin
        w[`EIA_STAT_BUSY_BIT] = st.busy;
        w[`EIA_STAT_IDX_BIT] = st.indexed;
        w[`EIA_STAT_EAV_BIT] = st.ea_valid;
        w[`EIA_STAT_CNT_LSB +: `EIA_CNT_W] = st.icount;
      end
      `EIA_OFS_EA: w[`EIA_PTR_W-1:0] = st.ea;
      default: w = 32'h0;
    endcase
    return w;
  endfunction

  // Decode and operand address from the held opcode
  eia_addr_gen u_agen (
    .i_opcode(s_q.opc),
    .i_ext_en(s_q.ext_en),
    .i_frame_ptr(s_q.ptr[2]),
    .i_bank(s_q.bank),
    .o_dec(dec),
    .o_addr(agen_addr),
    .o_indexed(agen_idx)
  );

  // The return form always works on pointer two
  assign sel_eff = dec.is_ret ? `EIA_SEL_FRAME : dec.sel;

  // Pick the pointer that feeds the subtractor
  always_comb begin
    case (sel_eff)
      2'h0: sub_in = s_q.ptr[0];
      2'h1: sub_in = s_q.ptr[1];
      default: sub_in = s_q.ptr[2];
    endcase
  end

  eia_ptr_sub u_sub (
    .i_ptr(sub_in),
    .i_lit(dec.lit),
    .o_diff(sub_out)
  );

  // Address phase is taken when selected, non-idle and the bus is ready
  assign acc = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready;

  // Next state: phase divider, bus slave, then the phase sequencer
  always_comb begin
    s_d = s_q;
    tick = (s_q.div == `EIA_Q_DIV_LAST);
    s_d.div = tick ? 4'h0 : s_q.div + 4'h1;
    s_d.ret_pulse = 1'b0;
    s_d.hready = 1'b1;
    s_d.hresp = 1'b0;
    s_d.wr_pend = 1'b0;
    s_d.hrdata = 32'h0;

    // Read data is fetched at the address phase so it leaves a flop
    if (acc) begin
      s_d.wr_pend = i_ahb.hwrite;
      s_d.wr_ofs = i_ahb.haddr[7:0];
      s_d.wr_map = (i_ahb.haddr[31:8] == 24'h0);
      if (!i_ahb.hwrite && (i_ahb.haddr[31:8] == 24'h0)) begin
        s_d.hrdata = rd_word(s_q, i_ahb.haddr[7:0]);
      end
    end

    // Writes land only while idle, so software never races a writeback
    if (s_q.wr_pend && s_q.wr_map && (s_q.st == ST_IDLE)) begin
      case (s_q.wr_ofs)
        `EIA_OFS_CTRL: s_d.ext_en = i_ahb.hwdata[`EIA_CTRL_EXT_BIT];
        `EIA_OFS_PTR0: s_d.ptr[0] = i_ahb.hwdata[`EIA_PTR_W-1:0];
        `EIA_OFS_PTR1: s_d.ptr[1] = i_ahb.hwdata[`EIA_PTR_W-1:0];
        `EIA_OFS_PTR2: s_d.ptr[2] = i_ahb.hwdata[`EIA_PTR_W-1:0];
        `EIA_OFS_TOS: s_d.return_stack_top = i_ahb.hwdata[`EIA_PC_W-1:0];
        `EIA_OFS_PC: s_d.pc = i_ahb.hwdata[`EIA_PC_W-1:0];
        `EIA_OFS_BANK: s_d.bank = i_ahb.hwdata[3:0];
        `EIA_OFS_OPC: begin
          s_d.opc = i_ahb.hwdata[`EIA_OPC_W-1:0];
          s_d.st = ST_Q1;
          s_d.ea_valid = 1'b0;
          s_d.indexed = 1'b0;
        end
        default: s_d.opc = s_q.opc;
      endcase
    end

    // Four phases per instruction cycle, each one divider tick long
    if (tick) begin
      case (s_q.st)
        ST_IDLE: s_d.nop_cnt = 2'h0;
        ST_Q1: s_d.st = ST_Q2;
        ST_Q2: begin
          // Operand address settles while the operand would be read
          s_d.st = ST_Q3;
          s_d.ea = agen_addr;
          s_d.indexed = agen_idx;
          s_d.ea_valid = dec.has_acc;
        end
        ST_Q3: s_d.st = ST_Q4;
        ST_Q4: begin
          // Pointer writeback in the last phase, executed count steps too
          if (dec.is_psub) begin
            case (sel_eff)
              2'h0: s_d.ptr[0] = sub_out;
              2'h1: s_d.ptr[1] = sub_out;
              default: s_d.ptr[2] = sub_out;
            endcase
          end
          s_d.icount = s_q.icount + 8'h01;
          if (dec.is_ret) begin
            s_d.pc = s_q.return_stack_top;
            s_d.ret_pulse = 1'b1;
            s_d.st = ST_NOP;
            s_d.nop_cnt = 2'h0;
          end else begin
            s_d.pc = s_q.pc + `EIA_PC_STEP;
            s_d.st = ST_IDLE;
          end
        end
        ST_NOP: begin
          // Second cycle of the return form does nothing
          if (s_q.nop_cnt == `EIA_NOP_LAST) begin
            s_d.st = ST_IDLE;
          end else begin
            s_d.nop_cnt = s_q.nop_cnt + 2'h1;
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
    end
    s_d.busy = (s_d.st != ST_IDLE);
  end

  // State register; reset leaves the extended set disabled
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
      s_q.ext_en <= `EIA_RST_EXT;
      s_q.ptr[0] <= `EIA_RST_PTR;
      s_q.ptr[1] <= `EIA_RST_PTR;
      s_q.ptr[2] <= `EIA_RST_PTR;
      s_q.pc <= `EIA_RST_PC;
      s_q.return_stack_top <= `EIA_RST_PC;
      s_q.bank <= `EIA_RST_BANK;
      s_q.st <= ST_IDLE;
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from state flops
  assign o_ahb.hreadyout = s_q.hready;
  assign o_ahb.hresp = s_q.hresp;
  assign o_ahb.hrdata = s_q.hrdata;
  assign o_core.pc = s_q.pc;
  assign o_core.operand_addr = s_q.ea;
  assign o_core.operand_valid = s_q.ea_valid;
  assign o_core.operand_indexed = s_q.indexed;
  assign o_core.busy = s_q.busy;
  assign o_core.ret_taken = s_q.ret_pulse;

endmodule
`default_nettype wire

// file: core/eia_params.svh
// Constants of the extended indexed addressing block: widths, offsets,
// field positions, reset values, opcode fields and phase timing.
// Assumes inclusion by bare name from files under core/.
`ifndef EIA_PARAMS_SVH
`define EIA_PARAMS_SVH

// Widths
`define EIA_PTR_W 12
`define EIA_PC_W 21
`define EIA_OPC_W 16
`define EIA_CNT_W 8

// Register byte offsets on the bus
`define EIA_OFS_CTRL 8'h00
`define EIA_OFS_PTR0 8'h04
`define EIA_OFS_PTR1 8'h08
`define EIA_OFS_PTR2 8'h0c
`define EIA_OFS_TOS 8'h10
`define EIA_OFS_PC 8'h14
`define EIA_OFS_BANK 8'h18
`define EIA_OFS_OPC 8'h1c
`define EIA_OFS_STAT 8'h20
`define EIA_OFS_EA 8'h24

// Field positions
`define EIA_CTRL_EXT_BIT 0
`define EIA_STAT_BUSY_BIT 0
`define EIA_STAT_IDX_BIT 1
`define EIA_STAT_EAV_BIT 2
`define EIA_STAT_CNT_LSB 8

// Reset values
`define EIA_RST_EXT 1'b0
`define EIA_RST_PTR 12'h000
`define EIA_RST_PC 21'h000000
`define EIA_RST_BANK 4'h0

// Opcode fields
`define EIA_OPC_PSUB 8'he9
`define EIA_SEL_RET 2'h3
`define EIA_SEL_FRAME 2'h2
`define EIA_IDX_LIMIT 8'h5f
`define EIA_ACC_HI_BASE 4'hf
`define EIA_PC_STEP 21'h000002

// Timing: clocks per phase minus one, and last phase of the idle cycle
`define EIA_Q_DIV_LAST 4'h0
`define EIA_NOP_LAST 2'h3

`endif

// file: core/eia_pkg.sv
// Types of the extended indexed addressing block: phase states, bus
// carriers, decode result and the core output record of the top module.
// Assumes eia_params.svh is reachable by bare name.
`include "eia_params.svh"

package eia_pkg;

  // Instruction phases, Gray coded from idle through the fourth phase
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_Q1 = 3'h1,
    ST_Q2 = 3'h3,
    ST_Q3 = 3'h2,
    ST_Q4 = 3'h6,
    ST_NOP = 3'h7
  } eia_phase_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } eia_ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } eia_ahb_rsp_t;

  typedef struct packed {
    logic [`EIA_PC_W-1:0] pc;
    logic [`EIA_PTR_W-1:0] operand_addr;
    logic operand_valid;
    logic operand_indexed;
    logic busy;
    logic ret_taken;
  } eia_core_out_t;

  typedef struct packed {
    logic is_psub;
    logic is_ret;
    logic has_acc;
    logic acc_bit;
    logic [1:0] sel;
    logic [5:0] lit;
    logic [7:0] file;
  } eia_dec_t;

endpackage

// file: core/eia_ptr_sub.sv
// Pointer minus a six-bit unsigned literal, wrapping at pointer width.
// Assumes the caller picks the pointer and commits the result.
`timescale 1ns/1ps
`default_nettype none
`include "eia_params.svh"

module eia_ptr_sub (
  input wire logic [`EIA_PTR_W-1:0] i_ptr,
  input wire logic [5:0] i_lit,
  output logic [`EIA_PTR_W-1:0] o_diff
);
  import eia_pkg::*;

  // Plain modulo subtract; underflow raises nothing and touches no flag
  assign o_diff = i_ptr - {6'h00, i_lit};

endmodule
`default_nettype wire

// file: core/eia_addr_gen.sv
// Opcode decode and operand address former for byte and bit operations.
// Assumes a stable opcode, frame pointer and bank while it is sampled.
`timescale 1ns/1ps
`default_nettype none
`include "eia_params.svh"

module eia_addr_gen (
  input wire logic [`EIA_OPC_W-1:0] i_opcode,
  input wire logic i_ext_en,
  input wire logic [`EIA_PTR_W-1:0] i_frame_ptr,
  input wire logic [3:0] i_bank,
  output eia_pkg::eia_dec_t o_dec,
  output logic [`EIA_PTR_W-1:0] o_addr,
  output logic o_indexed
);
  import eia_pkg::*;

  logic [3:0] grp;
  logic byte_op;
  logic bit_op;
  logic low_f;

  // Byte ops fill groups 0..6 except the misc and literal rows of group 0
  assign grp = i_opcode[15:12];
  assign byte_op = (grp <= 4'h6) && (i_opcode[15:9] != 7'h00) && (i_opcode[15:11] != 5'h01);
  assign bit_op = (grp >= 4'h7) && (grp <= 4'hb);
  assign low_f = (i_opcode[7:0] <= `EIA_IDX_LIMIT);

  // One enable opens both the new opcodes and the indexed mode
  always_comb begin
    o_dec.is_psub = i_ext_en && (i_opcode[15:8] == `EIA_OPC_PSUB);
    o_dec.sel = i_opcode[7:6];
    o_dec.is_ret = o_dec.is_psub && (i_opcode[7:6] == `EIA_SEL_RET);
    o_dec.lit = i_opcode[5:0];
    o_dec.has_acc = byte_op || bit_op;
    o_dec.acc_bit = i_opcode[8];
    o_dec.file = i_opcode[7:0];
  end

  // Operand address; a zero frame pointer lands on the low access region
  always_comb begin
    o_indexed = 1'b0;
    if (o_dec.has_acc && i_ext_en && !o_dec.acc_bit && low_f) begin
      o_addr = i_frame_ptr + {4'h0, o_dec.file};
      o_indexed = 1'b1;
    end else if (!o_dec.acc_bit) begin
      o_addr = low_f ? {4'h0, o_dec.file} : {`EIA_ACC_HI_BASE, o_dec.file};
    end else begin
      o_addr = {i_bank, o_dec.file};
    end
  end

endmodule
`default_nettype wire

// file: bench/eia_checker.sv
// Checker of the pointer subtract and indexed addressing block.
// Sees only the top module ports; bound to eia_top at the foot.
`timescale 1ns/1ps
`default_nettype none
module eia_checker (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire eia_pkg::eia_ahb_req_t i_ahb,
  input wire eia_pkg::eia_ahb_rsp_t o_ahb,
  input wire eia_pkg::eia_core_out_t o_core
);
  import eia_pkg::*;
  logic rd_q;
  // Read taken at the last edge; hrdata must be zero in any other cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= i_ahb.hsel && i_ahb.htrans[1] && !i_ahb.hwrite && i_ahb.hready;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  chk_bus_okay: assert property (o_ahb.hreadyout && !o_ahb.hresp)
    else $error("bus answer not ready or not okay");
  chk_rdata_idle: assert property (!rd_q |-> o_ahb.hrdata == 32'h00000000)
    else $error("read data outside data phase");
  chk_ret_pulse: assert property (o_core.ret_taken |=> !o_core.ret_taken)
    else $error("return pulse longer than one cycle");
  chk_ret_nop: assert property (o_core.ret_taken |-> o_core.busy [*4] ##1 !o_core.busy)
    else $error("idle second cycle of return wrong length");
  chk_ret_start: assert property (o_core.ret_taken |-> $past(o_core.busy, 4))
    else $error("return not four phases after launch");
  chk_busy_len: assert property ($rose(o_core.busy) |->
    o_core.busy [*4] ##1 (!o_core.busy || o_core.ret_taken))
    else $error("instruction cycle not four phases");
  chk_idx_valid: assert property (o_core.operand_indexed |-> o_core.operand_valid)
    else $error("indexed flag without operand");
  chk_pc_step: assert property ($fell(o_core.busy) && !$past(o_core.ret_taken, 4) |->
    o_core.pc - $past(o_core.pc) == 21'h000002)
    else $error("pc not advanced by one instruction");
  cov_ret: cover property (o_core.ret_taken);
  cov_idx: cover property ($rose(o_core.operand_indexed));
  cov_done: cover property ($fell(o_core.busy));
endmodule
bind eia_top eia_checker u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_ahb(i_ahb),
  .o_ahb(o_ahb), .o_core(o_core));
`default_nettype wire

// file: bench/eia_tb_top.sv
// Bench of the extended indexed addressing block: bus tasks, scenarios.
// Drives the top ports itself; one clock, asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "eia_params.svh"
module eia_tb_top;
  import eia_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  eia_ahb_req_t req = '0;
  eia_ahb_rsp_t rsp;
  eia_core_out_t core;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int rets = 0;
  logic [31:0] rd;
  eia_top i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_ahb(req), .o_ahb(rsp), .o_core(core));
  // 200 MHz
  always #2.5 i_clk = ~i_clk;
  // Count return pulses; the run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cyc++;
    if (core.ret_taken === 1'b1) rets++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", w, e, g);
    end
  endtask
  // Single word transfer; each phase held until hready is sampled high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    req.hsel <= 1'b1;
    req.haddr <= {24'h000000, a};
    req.htrans <= 2'h2;
    req.hwrite <= wr;
    do @(posedge i_clk); while (rsp.hreadyout !== 1'b1);
    req.hsel <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= d;
    do @(posedge i_clk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask
  task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(w, e, rd);
  endtask
  // Launch one opcode; busy is looked at mid-cycle to stay clear of the edge
  task automatic run(input logic [15:0] o);
    bus(1'b1, `EIA_OFS_OPC, {16'h0000, o});
    @(negedge i_clk);
    while (core.busy !== 1'b0) @(negedge i_clk);
    @(posedge i_clk);
  endtask
  task automatic t_reset();
    rdc("ext", `EIA_OFS_CTRL, 32'h00000000);
    rdc("hole", 8'h28, 32'h00000000);
  endtask
  // Each pointer: plain subtract, wrap below zero, zero literal; then disabled
  task automatic t_sub();
    logic [7:0] a;
    bus(1'b1, `EIA_OFS_CTRL, 32'h00000001);
    bus(1'b1, `EIA_OFS_PC, 32'h00000100);
    for (int s = 0; s < 3; s++) begin
      a = 8'(4 + 4 * s);
      bus(1'b1, a, 32'h000003ff);
      run({8'he9, 2'(s), 6'h23});
      rdc("sub", a, 32'h000003dc);
      bus(1'b1, a, 32'h00000010);
      run({8'he9, 2'(s), 6'h3f});
      rdc("wrap", a, 32'h00000fd1);
      run({8'he9, 2'(s), 6'h00});
      rdc("zero", a, 32'h00000fd1);
    end
    chk("pc", 32'h00000112, {11'h000, core.pc});
    bus(1'b1, `EIA_OFS_CTRL, 32'h00000000);
    run(16'he9a3);
    rdc("off", `EIA_OFS_PTR2, 32'h00000fd1);
  endtask
  // Subtract and return from pointer two; pointer zero must not move
  task automatic t_ret();
    int n;
    bus(1'b1, `EIA_OFS_CTRL, 32'h00000001);
    bus(1'b1, `EIA_OFS_PTR2, 32'h000003ff);
    bus(1'b1, `EIA_OFS_TOS, 32'h00001234);
    n = rets;
    run(16'he9e3);
    rdc("rptr", `EIA_OFS_PTR2, 32'h000003dc);
    rdc("p0", `EIA_OFS_PTR0, 32'h00000fd1);
    rdc("rpc", `EIA_OFS_PC, 32'h00001234);
    chk("rets", 32'(n + 1), 32'(rets));
    rdc("stat", `EIA_OFS_STAT, 32'h00000b00);
  endtask
  task automatic acase(input logic e, input logic [11:0] p, input logic [15:0] o,
      input logic [11:0] ea, input logic ix);
    bus(1'b1, `EIA_OFS_CTRL, {31'h00000000, e});
    bus(1'b1, `EIA_OFS_PTR2, {20'h00000, p});
    run(o);
    chk("ea", {20'h00000, ea}, {20'h00000, core.operand_addr});
    chk("mode", {30'h0, 1'b1, ix}, {30'h0, core.operand_valid, core.operand_indexed});
    rdc("ea_reg", `EIA_OFS_EA, {20'h00000, ea});
  endtask
  // Operand address forms across enable, access bit and the 5Fh boundary
  task automatic t_addr();
    bus(1'b1, `EIA_OFS_BANK, 32'h00000005);
    acase(1'b1, 12'ha00, 16'h242c, 12'ha2c, 1'b1);
    acase(1'b1, 12'ha00, 16'h245f, 12'ha5f, 1'b1);
    acase(1'b1, 12'ha00, 16'h2460, 12'hf60, 1'b0);
    acase(1'b1, 12'ha00, 16'h252c, 12'h52c, 1'b0);
    acase(1'b0, 12'ha00, 16'h242c, 12'h02c, 1'b0);
    acase(1'b0, 12'ha00, 16'h252c, 12'h52c, 1'b0);
    acase(1'b1, 12'h000, 16'h242c, 12'h02c, 1'b1);
    acase(1'b1, 12'hfff, 16'h8e0a, 12'h009, 1'b1);
  endtask
  initial begin
    req.hsize = 3'h2;
    req.hready = 1'b1;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_sub();
    t_ret();
    t_addr();
    end_sim();
  end
endmodule
`default_nettype wire
